// ==== shared/idle_power_manager_map.svh ====
// Offsets, field positions and timing constants of the idle power manager
//
// Functional notes
// - Idle past interval stops pump and drivers
// - Idle interval lies between fifteen and sixty seconds
// - Any driver or receiver transition wakes pump and drivers outside legacy mode
// - Legacy mode sleeps on float, wakes on cable
// - Receivers stay enabled during idle standby
// - Power-down input low disables receiver outputs
// - Monitor receiver output stays active always
// - Cable-live high when any receiver sees line
// - Cable-live identical in both power modes
// - Force-active input overrides idle timeout
// - Driver activity wakes pump without line voltage
// - Pump phases cycle in fixed four-step order
// - Pump pauses while both rails are regulated
// - Running pump phase clock exceeds seventy kilohertz
// - Cable-live loopback gives wake and forced shutdown
// - Any shutdown stops pump and disables drivers
`ifndef IDLE_POWER_MANAGER_MAP_SVH
`define IDLE_POWER_MANAGER_MAP_SVH

// Clock and timing
`define CLK_MHZ 100
`define IDLE_S 30
`define IDLE_MIN_S 15
`define IDLE_MAX_S 60
`define TICK_MS 1
`define TICK_CYC (`CLK_MHZ * 1000 * `TICK_MS)
`define IDLE_TICKS (`IDLE_S * 1000 / `TICK_MS)
`define PUMP_MIN_KHZ 70
`define PUMP_KHZ 100
`define PUMP_PHASE_CYC (`CLK_MHZ * 1000 / (`PUMP_KHZ * 4))

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0c

// Control fields
`define CTRL_FORCE 0
`define CTRL_LEGACY 1
`define CTRL_PDOWN 2
`define CTRL_RESET 3'h0

// State fields
`define ST_PUMP 0
`define ST_DRV 1
`define ST_CABLE 2
`define ST_STBY 3
`define ST_SHUT 4

// Interrupt fields
`define IRQ_STANDBY 0
`define IRQ_WAKE 1
`define IRQ_CABLE 2
`define IRQ_SHUT 3
`define IRQ_RESET 4'h0

`endif

// ==== shared/idle_power_pkg.sv ====
// Types shared by the idle power manager
package idle_power_pkg;

  // Power state, one-hot
  typedef enum logic [2:0] {
    ST_ACTIVE   = 3'b001,
    ST_STANDBY  = 3'b010,
    ST_SHUTDOWN = 3'b100
  } pwr_state_t;

  // Charge pump phase, one-hot
  typedef enum logic [3:0] {
    PH_NCHG  = 4'b0001,
    PH_NXFER = 4'b0010,
    PH_PCHG  = 4'b0100,
    PH_PXFER = 4'b1000
  } pump_phase_t;

  // Synchronised control pins
  typedef struct packed {
    logic online;
    logic shutdown_n;
    logic vpos_ok;
    logic vneg_ok;
  } ctl_pins_t;

endpackage

// ==== src/idle_power_manager.sv ====
// Idle power manager with charge pump sequencer and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_manager_map.svh"

module idle_power_manager
  import idle_power_pkg::*;
#(
  parameter int N_DRV = 3,
  parameter int N_RX = 5,
  parameter int TICK_CYCLES = `TICK_CYC,
  parameter int IDLE_TICKS = `IDLE_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_DRV-1:0] driver_input,
  input wire logic [N_RX-1:0] receiver_input,
  input wire logic [N_RX-1:0] rx_above_thr,
  input wire logic online,
  input wire logic shutdown_n,
  input wire logic vpos_ok,
  input wire logic vneg_ok,
  output logic drv_en,
  output logic pump_en,
  output logic [3:0] pump_phase,
  output logic [N_RX-1:0] rx_out,
  output logic rx_out_en,
  output logic monitor_rx_out,
  output logic cable_live,
  output logic irq
);

  // ----------------------------------------
  // Local sizes
  // ----------------------------------------
  localparam int SW = N_DRV + 2 * N_RX + 4;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int IW = $clog2(IDLE_TICKS + 1);
  localparam int PW = $clog2(`PUMP_PHASE_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [IW-1:0] IDLE_END = IW'(IDLE_TICKS);
  localparam logic [PW-1:0] PH_LAST = PW'(`PUMP_PHASE_CYC - 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] pins_raw; // All asynchronous inputs
  logic [SW-1:0] meta_q; // First stage, read only by sync_q
  logic [SW-1:0] sync_q; // Second stage, safe to use
  logic [N_DRV+N_RX-1:0] prev_q; // Last driver and receiver sample
  ctl_pins_t ctl_s; // Synchronised control pins
  logic [N_DRV-1:0] drv_s; // Synchronised driver inputs
  logic [N_RX-1:0] rx_s; // Synchronised receiver levels
  logic [N_RX-1:0] thr_s; // Synchronised threshold detectors
  logic activity; // Any monitored input changed
  logic cable_now; // Any receiver beyond line threshold

  assign pins_raw = {driver_input, receiver_input, rx_above_thr,
                     online, shutdown_n, vpos_ok, vneg_ok};

  // Two flops, then one more for edge compare
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q[SW-1:N_RX+4];
    end
  end

  assign drv_s = sync_q[SW-1 -: N_DRV];
  assign rx_s = sync_q[2*N_RX+3 -: N_RX];
  assign thr_s = sync_q[N_RX+3 -: N_RX];
  assign ctl_s = sync_q[3:0];
  // Transitions on driver or receiver levels
  assign activity = |(sync_q[SW-1:N_RX+4] ^ prev_q);
  assign cable_now = |thr_s;

  // ----------------------------------------
  // Register file state
  // ----------------------------------------
  logic [2:0] ctrl_q; // Force, legacy, power-down bits
  logic [3:0] irq_stat_q; // Sticky events
  logic [3:0] irq_mask_q; // Interrupt enables
  logic [3:0] irq_ev; // Events this cycle
  logic [3:0] irq_clr; // Write-one-to-clear bits
  logic wb_req; // New bus request
  logic wb_wr; // Write with low lane enabled

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic force_sd; // Manual power-down request
  logic force_on; // Force-active request
  logic legacy; // Cable-detect emulation mode

  // Pin low or software bit forces shutdown
  assign force_sd = !ctl_s.shutdown_n || ctrl_q[`CTRL_PDOWN];
  assign force_on = ctl_s.online || ctrl_q[`CTRL_FORCE];
  assign legacy = ctrl_q[`CTRL_LEGACY];

  // ----------------------------------------
  // Idle timer on a slow tick
  // ----------------------------------------
  logic [TW-1:0] tick_cnt_q; // Cycles within one tick
  logic [IW-1:0] idle_cnt_q; // Idle ticks so far
  logic idle_done; // Interval reached
  pwr_state_t state_q; // Present power state
  pwr_state_t state_d; // Next power state

  // Restart on activity or outside active state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      idle_cnt_q <= '0;
    end else if (activity || state_q != ST_ACTIVE) begin
      tick_cnt_q <= '0;
      idle_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      // Saturate at the interval
      if (idle_cnt_q != IDLE_END) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  assign idle_done = (idle_cnt_q == IDLE_END);

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  // Mode transitions, then overrides by priority
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        // Idle interval elapsed; a transition in the same cycle wins
        if (idle_done && !activity) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        // Wake on any transition
        if (activity) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SHUTDOWN: begin
        // Released from shutdown
        state_d = ST_ACTIVE;
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
    // Legacy mode follows cable presence only
    if (legacy) begin
      state_d = cable_now ? ST_ACTIVE : ST_STANDBY;
    end
    // Force-active beats idle
    if (force_on) begin
      state_d = ST_ACTIVE;
    end
    // Manual shutdown beats everything
    if (force_sd) begin
      state_d = ST_SHUTDOWN;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Line-side outputs
  // ----------------------------------------
  logic drv_en_q; // Drivers powered
  logic pump_en_q; // Charge pump allowed
  logic rx_en_q; // Receiver outputs enabled
  logic [N_RX-1:0] rx_out_q; // Receiver data
  logic mon_q; // Monitor receiver data
  logic cable_q; // Cable-live level

  // Enables follow the next state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drv_en_q <= 1'b0;
      pump_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else begin
      drv_en_q <= (state_d == ST_ACTIVE);
      pump_en_q <= (state_d == ST_ACTIVE);
      rx_en_q <= (state_d != ST_SHUTDOWN);
    end
  end

  // Receiver data, monitor and cable-live in every mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_q <= '0;
      mon_q <= 1'b0;
      cable_q <= 1'b0;
    end else begin
      rx_out_q <= rx_s;
      mon_q <= rx_s[1];
      cable_q <= cable_now;
    end
  end

  // ----------------------------------------
  // Charge pump sequencer
  // ----------------------------------------
  pump_phase_t phase_q; // Present pump phase
  pump_phase_t phase_nx; // Following phase
  logic [PW-1:0] ph_cnt_q; // Cycles in present phase
  logic pump_need; // A rail is below regulation

  assign pump_need = pump_en_q && !(ctl_s.vpos_ok && ctl_s.vneg_ok);

  // Fixed order; fourth phase returns to the first
  always_comb begin
    case (phase_q)
      PH_NCHG: phase_nx = PH_NXFER;
      PH_NXFER: phase_nx = PH_PCHG;
      PH_PCHG: phase_nx = PH_PXFER;
      PH_PXFER: phase_nx = PH_NCHG;
      default: phase_nx = PH_NCHG;
    endcase
  end

  // Step only while a rail needs charge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_NCHG;
      ph_cnt_q <= '0;
    end else if (!pump_en_q) begin
      phase_q <= PH_NCHG;
      ph_cnt_q <= '0;
    end else if (pump_need) begin
      // Phase length sets the pump rate
      if (ph_cnt_q == PH_LAST) begin
        ph_cnt_q <= '0;
        phase_q <= phase_nx;
      end else begin
        ph_cnt_q <= ph_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Entry into standby, wake, cable change, shutdown
  assign irq_ev[`IRQ_STANDBY] = (state_d == ST_STANDBY) &&
                                (state_q != ST_STANDBY);
  assign irq_ev[`IRQ_WAKE] = (state_d == ST_ACTIVE) &&
                             (state_q != ST_ACTIVE);
  assign irq_ev[`IRQ_CABLE] = (cable_now != cable_q);
  assign irq_ev[`IRQ_SHUT] = (state_d == ST_SHUTDOWN) &&
                             (state_q != ST_SHUTDOWN);
  assign irq_clr = (wb_wr && wb_adr_i == `REG_IRQ_STAT) ?
                   wb_dat_i[3:0] : 4'h0;

  // Sticky bits; a new event beats a clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= `IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  // Level output from the masked status
  logic irq_q; // Interrupt line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic ack_q; // One-cycle acknowledge
  logic [31:0] rdat_q; // Read data

  // Writable registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
      irq_mask_q <= `IRQ_RESET;
    end else if (wb_wr) begin
      if (wb_adr_i == `REG_CTRL) begin
        ctrl_q <= wb_dat_i[2:0];
      end
      if (wb_adr_i == `REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[3:0];
      end
    end
  end

  // Acknowledge and read data, zero when unmapped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: rdat_q <= {29'h0, ctrl_q};
          `REG_STATE: rdat_q <= {27'h0, state_q == ST_SHUTDOWN,
                                 state_q == ST_STANDBY, cable_q,
                                 drv_en_q, pump_en_q};
          `REG_IRQ_STAT: rdat_q <= {28'h0, irq_stat_q};
          `REG_IRQ_MASK: rdat_q <= {28'h0, irq_mask_q};
          default: rdat_q <= 32'h0;
        endcase
      end else begin
        rdat_q <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // Output wiring
  // ----------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign drv_en = drv_en_q;
  assign pump_en = pump_en_q;
  assign pump_phase = phase_q;
  assign rx_out = rx_out_q;
  assign rx_out_en = rx_en_q;
  assign monitor_rx_out = mon_q;
  assign cable_live = cable_q;
  assign irq = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Timeout drops drivers within two edges
  property p_idle_off;
    (idle_done && !force_on && !force_sd && !legacy && !activity)
      |-> ##[1:2] (!drv_en_q && !pump_en_q);
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("idle timeout did not stop drivers");

  // Transition wakes pump quickly
  property p_wake;
    (activity && !force_sd && !legacy) |-> ##1 pump_en_q && drv_en_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("activity did not wake pump");

  // Legacy mode tracks cable presence
  property p_legacy;
    (legacy && !force_on && !force_sd) |-> ##1 (pump_en_q == $past(cable_now));
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy mode ignored cable state");

  // Receivers enabled outside shutdown
  property p_rx_on;
    (!force_sd) |-> ##1 rx_en_q;
  endproperty
  a_rx_on: assert property (p_rx_on)
    else $error("receivers disabled outside shutdown");

  // Shutdown disables receivers, pump and drivers
  property p_shut;
    force_sd |-> ##1 (!rx_en_q && !pump_en_q && !drv_en_q);
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown left outputs enabled");

  // Monitor output follows receiver two always
  property p_mon;
    ##1 (mon_q == $past(rx_s[1]));
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor output stale");

  // Cable-live follows threshold detectors
  property p_cable;
    ##1 (cable_q == $past(cable_now));
  endproperty
  a_cable: assert property (p_cable)
    else $error("cable-live wrong");

  // Force-active keeps device on
  property p_force;
    (force_on && !force_sd) |-> ##1 pump_en_q;
  endproperty
  a_force: assert property (p_force)
    else $error("force-active did not hold device on");

  // Positive charge phase entered only after negative transfer
  property p_order;
    (phase_q == PH_PCHG && $past(phase_q) != PH_PCHG)
      |-> $past(phase_q) == PH_NXFER;
  endproperty
  a_order: assert property (p_order)
    else $error("pump phase order broken");

  // Regulated rails pause the pump
  property p_pause;
    (pump_en_q && !pump_need) |=> $stable(ph_cnt_q) || !pump_en_q;
  endproperty
  a_pause: assert property (p_pause)
    else $error("pump ran with rails regulated");

endmodule
`default_nettype wire

// ==== tb/idle_power_manager_bench.sv ====
// Self-checking bench for the idle power manager
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("MISMATCH at %0t: got %0h exp %0h", $time, g, e); \
  end \
end

module idle_power_manager_bench;
  import idle_power_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 0;
  logic rst_n = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] driver_input = '0;
  logic [4:0] receiver_input = '0;
  logic [4:0] rx_above_thr;
  logic online = 0;
  logic shutdown_n = 1;
  logic vpos_ok, vneg_ok, drv_en, pump_en, rx_out_en;
  logic monitor_rx_out, cable_live, irq;
  logic [3:0] pump_phase;
  logic [4:0] rx_out;
  logic line_live = 0; // Far side drives line voltage
  logic rail_load = 0; // Heavy load pulls a rail down
  logic loop = 0; // Cable-live looped to control pins
  int failures = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int seed = 35;
  logic [31:0] exp_q[$]; // Expected read data
  logic [31:0] exp_w; // Oldest note, taken once per answer

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  idle_power_manager #(.N_DRV(3), .N_RX(5), .TICK_CYCLES(4),
    .IDLE_TICKS(5)) u_idle_power_manager (.clk_sys(clk_sys),
    .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .driver_input(driver_input), .receiver_input(receiver_input),
    .rx_above_thr(rx_above_thr), .online(online),
    .shutdown_n(shutdown_n), .vpos_ok(vpos_ok), .vneg_ok(vneg_ok),
    .drv_en(drv_en), .pump_en(pump_en), .pump_phase(pump_phase),
    .rx_out(rx_out), .rx_out_en(rx_out_en),
    .monitor_rx_out(monitor_rx_out), .cable_live(cable_live),
    .irq(irq));

  line_partner #(.N_RX(5)) u_line_partner (.clk_sys(clk_sys),
    .rst_n(rst_n), .line_live(line_live), .rail_load(rail_load),
    .pump_en(pump_en), .pump_phase(pump_phase),
    .rx_above_thr(rx_above_thr), .vpos_ok(vpos_ok), .vneg_ok(vneg_ok));

  // ----------------------------------------
  // Clock, loopback, watcher, timeout
  // ----------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Host holds the control pins, optionally from cable-live
  always @(posedge clk_sys) begin
    online <= loop & cable_live;
    shutdown_n <= ~loop | cable_live;
  end

  // Compare each read answer with the oldest note
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      exp_w = exp_q.size() ? exp_q.pop_front() : 32'hx;
      `CHK(wb_dat_o, exp_w)
    end
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One classic Wishbone cycle, entered just after an edge
  task automatic wb_cyc(input logic [7:0] a, input logic we,
                        input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read with expected data noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_cyc(a, 1'b0, 32'h0);
  endtask

  // Toggle one random driver input
  task automatic tog_drv();
    driver_input <= driver_input ^ (3'h1 << ({$random(seed)} % 3));
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Counts and verdict
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] ph;
    int n;
    wt(5);
    rst_n <= 1'b1;
    wt(10);
    // Register reset values, unmapped read, mask
    wb_cyc(8'h08, 1'b1, 32'hf);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    wb_cyc(8'h0c, 1'b1, 32'h1);
    rd(8'h0c, 32'h1);
    // Idle into standby, receivers stay on
    wt(40);
    rd(8'h04, 32'h08);
    `CHK(rx_out_en, 1'b1)
    `CHK({pump_en, drv_en}, 2'b00)
    `CHK(irq, 1'b1)
    wb_cyc(8'h08, 1'b1, 32'h1);
    wt(2);
    `CHK(irq, 1'b0)
    wb_cyc(8'h0c, 1'b1, 32'h0);
    // Driver activity wakes, masked event keeps irq low
    tog_drv();
    wt(8);
    rd(8'h04, 32'h03);
    rd(8'h08, 32'h02);
    `CHK(irq, 1'b0)
    // Activity restarts the idle timer: no standby entry meanwhile
    wb_cyc(8'h08, 1'b1, 32'h2);
    repeat (4) begin
      tog_drv();
      wt(12);
    end
    wt(4);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h03);
    // Receiver transition wakes from standby
    wt(40);
    receiver_input <= receiver_input ^ 5'(({$random(seed)} % 31) + 1);
    wt(8);
    rd(8'h04, 32'h03);
    // Force-active holds it on
    wb_cyc(8'h00, 1'b1, 32'h1);
    wt(40);
    rd(8'h04, 32'h03);
    // Pump phases under load
    rail_load <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      ph = pump_phase;
      n = 0;
      while (pump_phase === ph && n < 400) begin
        @(posedge clk_sys);
        n++;
      end
      `CHK(pump_phase, {ph[2:0], ph[3]})
      if (k > 0) `CHK(n, 250)
    end
    rail_load <= 1'b0;
    wt(1100);
    ph = pump_phase;
    wt(600);
    `CHK(pump_phase, ph)
    // Power-down bit
    wb_cyc(8'h00, 1'b1, 32'h4);
    wt(8);
    rd(8'h04, 32'h10);
    `CHK({pump_en, drv_en, rx_out_en}, 3'b000)
    // Cable-live looped to both pins, no line
    wb_cyc(8'h00, 1'b1, 32'h0);
    loop <= 1'b1;
    wt(16);
    rd(8'h04, 32'h10);
    `CHK(rx_out_en, 1'b0)
    // Monitor and raw receiver data follow both levels
    repeat (2) begin
      receiver_input <= receiver_input ^ 5'h02;
      wt(5);
      `CHK(monitor_rx_out, receiver_input[1])
      `CHK(rx_out, receiver_input)
    end
    line_live <= 1'b1;
    wt(16);
    rd(8'h04, 32'h07);
    `CHK({cable_live, drv_en, pump_en}, 3'b111)
    // Legacy cable-detect mode
    line_live <= 1'b0;
    loop <= 1'b0;
    wb_cyc(8'h00, 1'b1, 32'h2);
    wt(16);
    rd(8'h04, 32'h08);
    tog_drv();
    wt(8);
    rd(8'h04, 32'h08);
    wb_cyc(8'h08, 1'b1, 32'hf);
    wb_cyc(8'h0c, 1'b1, 32'h4);
    line_live <= 1'b1;
    wt(10);
    rd(8'h04, 32'h07);
    `CHK(irq, 1'b1)
    results();
  end
endmodule

`default_nettype wire

// ==== tb/line_partner.sv ====
// Far-side model: remote line detector and supply rail comparators
`timescale 1ns/1ps
`default_nettype none

module line_partner
  import idle_power_pkg::*;
#(
  parameter int N_RX = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_live,
  input wire logic rail_load,
  input wire logic pump_en,
  input wire logic [3:0] pump_phase,
  output logic [N_RX-1:0] rx_above_thr,
  output logic vpos_ok,
  output logic vneg_ok
);
  // ----------------------------------------
  // Line detector
  // ----------------------------------------
  // Only the top receiver sees line voltage; the rest float low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_above_thr <= '0;
    end else begin
      rx_above_thr <= line_live ? N_RX'(1) << (N_RX - 1) : '0;
    end
  end

  // ----------------------------------------
  // Rails
  // ----------------------------------------
  // Negative rail decays with the pump off or under load, positive rail only with the pump off; both recover after transfer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vpos_ok <= 1'b0;
      vneg_ok <= 1'b0;
    end else if (!pump_en || rail_load) begin
      vneg_ok <= 1'b0;
      vpos_ok <= vpos_ok & pump_en;
    end else begin
      // Negative rail charged by its transfer phase
      if (pump_phase == PH_NXFER) begin
        vneg_ok <= 1'b1;
      end
      // Positive rail charged by its transfer phase
      if (pump_phase == PH_PXFER) begin
        vpos_ok <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire
